//--- design/apc_pkg.sv
package apc_pkg;
    // ***********************************************
    // register map
    // ***********************************************
    localparam logic [11:0] APC_AUDIO_CONTROL_OFS = 12'h10c;
    localparam logic [11:0] APC_FIELD_CFG_OFS = 12'h110;
    localparam logic [11:0] APC_STATUS_OFS = 12'h114;
    localparam logic [11:0] APC_FIFO_DATA_OFS = 12'h118;
    localparam logic [11:0] APC_FIFO_CODE_OFS = 12'h11c;

    // audio control fields
    localparam int APC_IOM_LO = 0;
    localparam int APC_EDGE_BIT = 2;
    localparam int APC_ORDER_BIT = 3;
    localparam int APC_PKT_BIT = 4;
    localparam int APC_PAR_BIT = 5;
    localparam int APC_BYTE_BIT = 6;
    localparam int APC_CAP_BIT = 7;
    localparam int APC_FEN_BIT = 8;
    localparam logic [31:0] APC_CTRL_RESET = 32'h0000_0000;
    // field config: line length [11:0], lines per field [23:12]
    localparam logic [31:0] APC_FIELD_RESET = 32'h0040_0010;

    // ***********************************************
    // status codes
    // ***********************************************
    localparam logic [3:0] APC_VALID_SAMPLE_CODE = 4'h0;
    localparam logic [3:0] APC_FIELD_START_CODE = 4'h6;
    localparam logic [3:0] APC_LINE_START_CODE = 4'h1;
    localparam logic [3:0] APC_LINE_END_CODE_1 = 4'hd;
    localparam logic [3:0] APC_FIELD_END_CODE = 4'hc;

    // ***********************************************
    // timing
    // ***********************************************
    localparam int APC_CLK_MHZ = 25;
    localparam int APC_SYNC_STAGES = 2;
    localparam logic [5:0] APC_CNT_RESET = 6'h00;
    localparam int APC_FIFO_DEPTH = 35;
endpackage

//--- design/apc_edge_sync.sv
module apc_edge_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    import apc_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } apc_sync_s;

    apc_sync_s q, d;

    // second stage and later only are read
    always_comb begin
        d = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.s2;
    assign rise = q.s2 & ~q.s3;
    assign fall = ~q.s2 & q.s3;
endmodule

//--- design/apc_ahb_slave.sv
module apc_ahb_slave (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic [11:0] wr_addr,
    output logic wr_en,
    output logic [11:0] rd_addr,
    output logic rd_en,
    input wire logic [31:0] rd_val
);
    import apc_pkg::*;

    typedef struct packed {
        logic [11:0] addr;
        logic wr;
        logic rd;
        logic [31:0] rdata;
    } apc_bus_s;

    apc_bus_s q, d;
    logic take;

    // always zero wait states: reads are answered from the address phase
    always_comb begin
        take = hsel & hready & htrans[1];
        d = q;
        d.wr = take & hwrite;
        d.rd = take & ~hwrite;
        d.addr = haddr;
        if (take & ~hwrite) begin
            d.rdata = rd_val;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign hrdata = q.rdata;
    assign wr_en = q.wr;
    assign wr_addr = q.addr;
    assign rd_addr = haddr;
    assign rd_en = take & ~hwrite;
endmodule

//--- design/apc_capture.sv
// Our own choice: the AHB-Lite interface to the registers.
module apc_capture (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [11:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic SERIAL_BIT_CLOCK,
    input wire logic WORD_STROBE,
    input wire logic SERIAL_DATA_IN,
    input wire logic [23:8] GPIO_IN
);
    import apc_pkg::*;

    // ***********************************************
    // types
    // ***********************************************
    typedef enum logic [2:0] {
        APC_IDLE = 3'b000,
        APC_FSTART = 3'b001,
        APC_DATA = 3'b010,
        APC_FEND = 3'b011,
        APC_GAP = 3'b100
    } apc_state_e;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] field;
        apc_state_e st;
        logic [7:0] shreg;
        logic [3:0] bitcnt;
        logic [31:0] acc;
        logic [2:0] nbytes;
        logic [11:0] line_bytes;
        logic [11:0] lines;
        logic first_in_line;
        logic [35:0] pend;
        logic pend_v;
        logic wr_last;
        logic [5:0] count;
        logic [5:0] wp;
        logic [5:0] rp;
        logic [2:0] sd_sync;
        logic [15:0] gp_s1;
        logic [15:0] gp_s2;
        logic [35:0] rd_word;
        logic overflow;
    } apc_cap_s;

    apc_cap_s q, d;
    logic [35:0] mem [APC_FIFO_DEPTH];

    // ***********************************************
    // pin synchronisers
    // ***********************************************
    logic bclk_lvl, bclk_rise, bclk_fall;
    logic ws_lvl, ws_rise, ws_fall;
    apc_edge_sync u_bclk (
        .clk(CLK_SYS),
        .rst(RST),
        .pin(SERIAL_BIT_CLOCK),
        .level(bclk_lvl),
        .rise(bclk_rise),
        .fall(bclk_fall)
    );
    apc_edge_sync u_ws (
        .clk(CLK_SYS),
        .rst(RST),
        .pin(WORD_STROBE),
        .level(ws_lvl),
        .rise(ws_rise),
        .fall(ws_fall)
    );

    // ***********************************************
    // register bus
    // ***********************************************
    logic [11:0] wr_addr, rd_addr;
    logic wr_en, rd_en;
    logic [31:0] rd_val;

    apc_ahb_slave u_bus (
        .clk(CLK_SYS),
        .rst(RST),
        .hsel(HSEL),
        .haddr(HADDR),
        .htrans(HTRANS),
        .hwrite(HWRITE),
        .hready(HREADY),
        .hwdata(HWDATA),
        .hrdata(HRDATA),
        .wr_addr(wr_addr),
        .wr_en(wr_en),
        .rd_addr(rd_addr),
        .rd_en(rd_en),
        .rd_val(rd_val)
    );

    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    function automatic logic [5:0] apc_next_ptr(input logic [5:0] p);
        apc_next_ptr = (p == 6'(APC_FIFO_DEPTH - 1)) ? 6'h00 : p + 6'h01;
    endfunction

    logic fifo_pop;
    always_comb begin
        fifo_pop = rd_en && rd_addr == APC_FIFO_CODE_OFS && q.count != APC_CNT_RESET;
        unique case (rd_addr)
            APC_AUDIO_CONTROL_OFS: rd_val = q.ctrl;
            APC_FIELD_CFG_OFS: rd_val = q.field;
            APC_STATUS_OFS: rd_val = {20'h0, q.overflow, q.st, q.count, q.bitcnt[1:0]};
            APC_FIFO_DATA_OFS: rd_val = q.rd_word[31:0];
            APC_FIFO_CODE_OFS: rd_val = {28'h0, mem[q.rp][35:32]};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // ***********************************************
    // mode decode
    // ***********************************************
    logic par_sel, iom0, pkt_mode, byte_res, edge_sel, lsb_first, cap_en, fifo_en;
    logic serial_mode, parallel_mode, fast_path;
    logic bit_edge, sdata;

    always_comb begin
        par_sel = q.ctrl[APC_PAR_BIT];
        iom0 = q.ctrl[APC_IOM_LO];
        pkt_mode = q.ctrl[APC_PKT_BIT];
        byte_res = q.ctrl[APC_BYTE_BIT];
        edge_sel = q.ctrl[APC_EDGE_BIT];
        lsb_first = q.ctrl[APC_ORDER_BIT];
        cap_en = q.ctrl[APC_CAP_BIT];
        fifo_en = q.ctrl[APC_FEN_BIT];
        parallel_mode = par_sel & ~iom0 & ~pkt_mode;
        fast_path = par_sel & iom0 & (q.ctrl[1:0] == 2'b01);
        serial_mode = (~par_sel & iom0 & pkt_mode) | (par_sel & iom0 & byte_res);
        // fast path still sees one system-clock sample per edge; limited by clock rate
        bit_edge = edge_sel ? bclk_fall : bclk_rise;
        sdata = q.sd_sync[1];
    end

    // ***********************************************
    // capture and packing
    // ***********************************************
    logic [7:0] sh_next;
    logic byte_done;
    logic [15:0] in_word;
    logic [2:0] in_n;
    logic [11:0] line_len;
    logic [31:0] acc_n;
    logic [2:0] nb;
    logic [11:0] lb;

    always_comb begin
        d = q;
        line_len = q.field[11:0];
        sh_next = lsb_first ? {sdata, q.shreg[7:1]} : {q.shreg[6:0], sdata};
        byte_done = 1'b0;
        in_word = 16'h0000;
        in_n = 3'd0;
        acc_n = q.acc;
        nb = q.nbytes;
        lb = q.line_bytes;
        d.sd_sync = {q.sd_sync[1:0], SERIAL_DATA_IN};
        d.gp_s1 = GPIO_IN;
        d.gp_s2 = q.gp_s1;
        if (wr_en) begin
            if (wr_addr == APC_AUDIO_CONTROL_OFS) begin
                d.ctrl = HWDATA;
            end
            if (wr_addr == APC_FIELD_CFG_OFS) begin
                d.field = HWDATA;
            end
        end
        // clear first so a drop in the same cycle still sets the flag
        if (wr_en && wr_addr == APC_STATUS_OFS && HWDATA[11]) begin
            d.overflow = 1'b0;
        end
        if (serial_mode && bit_edge) begin
            d.shreg = sh_next;
            d.bitcnt = q.bitcnt + 4'd1;
            if (pkt_mode && q.bitcnt == 4'd7) begin
                d.bitcnt = 4'd0;
                byte_done = 1'b1;
            end
        end
        if (serial_mode && (ws_rise || ws_fall)) begin
            if (!pkt_mode) begin
                byte_done = 1'b1;
            end
            d.bitcnt = 4'd0;
        end
        if (serial_mode && byte_done) begin
            in_word = {8'h00, (bit_edge ? sh_next : q.shreg)};
            in_n = 3'd1;
        end
        if (parallel_mode && (ws_rise || ws_fall)) begin
            in_word = byte_res ? {8'h00, q.gp_s2[7:0]} : q.gp_s2;
            in_n = byte_res ? 3'd1 : 3'd2;
        end
        // packer: little endian, line ends right justified
        d.wr_last = 1'b0;
        if (q.pend_v && !q.wr_last && q.count != 6'(APC_FIFO_DEPTH)) begin
            d.pend_v = 1'b0;
            d.wr_last = 1'b1;
        end
        unique case (q.st)
            APC_IDLE: begin
                if (cap_en && fifo_en) begin
                    d.st = APC_FSTART;
                end
            end
            APC_FSTART: begin
                if (!q.pend_v) begin
                    d.pend = {APC_FIELD_START_CODE, 32'h0000_0000};
                    d.pend_v = 1'b1;
                    d.st = APC_DATA;
                    d.first_in_line = 1'b1;
                    d.lines = 12'h000;
                    d.line_bytes = 12'h000;
                    d.nbytes = 3'd0;
                end
            end
            APC_DATA: begin
                if (in_n != 3'd0) begin
                    if (q.pend_v) begin
                        d.overflow = 1'b1;
                    end else begin
                        acc_n = (in_n == 3'd2) ? {in_word, q.acc[31:16]} : {in_word[7:0], q.acc[31:8]};
                        nb = q.nbytes + in_n;
                        lb = q.line_bytes + 12'(in_n);
                        d.acc = acc_n;
                        d.nbytes = nb;
                        d.line_bytes = lb;
                        if (lb >= line_len || nb == 3'd4) begin
                            d.pend_v = 1'b1;
                            d.nbytes = 3'd0;
                            d.acc = 32'h0000_0000;
                            d.first_in_line = 1'b0;
                            d.pend[31:0] = acc_n >> (6'(3'd4 - nb) * 6'd8); // right justified
                            if (lb >= line_len) begin
                                d.pend[35:32] = APC_LINE_END_CODE_1 + 4'(nb - 3'd1);
                                d.line_bytes = 12'h000;
                                d.first_in_line = 1'b1;
                                d.lines = q.lines + 12'h001;
                                if (q.lines + 12'h001 >= q.field[23:12]) begin
                                    d.st = APC_FEND;
                                end
                            end else if (q.first_in_line) begin
                                d.pend[35:32] = APC_LINE_START_CODE;
                            end else begin
                                d.pend[35:32] = APC_VALID_SAMPLE_CODE;
                            end
                        end
                    end
                end
            end
            APC_FEND: begin
                if (!q.pend_v) begin
                    d.pend = {APC_FIELD_END_CODE, 32'h0000_0000};
                    d.pend_v = 1'b1;
                    d.st = APC_GAP;
                end
            end
            APC_GAP: begin
                d.st = cap_en ? APC_FSTART : APC_IDLE;
            end
            default: d.st = APC_IDLE;
        endcase
        // fifo pointers and doubleword count
        if (d.wr_last) begin
            d.wp = apc_next_ptr(q.wp);
        end
        if (fifo_pop) begin
            d.rp = apc_next_ptr(q.rp);
            d.rd_word = mem[q.rp];
        end
        d.count = q.count + {5'h00, d.wr_last} - {5'h00, fifo_pop};
        if (!d.ctrl[APC_FEN_BIT]) begin
            d.count = APC_CNT_RESET;
            d.wp = 6'h00;
            d.rp = 6'h00;
            d.pend_v = 1'b0;
            d.st = APC_IDLE;
            d.nbytes = 3'd0;
            d.line_bytes = 12'h000;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            q <= '0;
            q.ctrl <= APC_CTRL_RESET;
            q.field <= APC_FIELD_RESET;
            q.st <= APC_IDLE;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (d.wr_last) begin
            mem[q.wp] <= q.pend;
        end
    end

    logic unused_ok;
    assign unused_ok = ^{HSIZE, bclk_lvl, ws_lvl, fast_path};
endmodule

//--- sim/apc_capture_monitor.sv
module apc_capture_monitor
    import apc_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [11:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // bus phase tracking
    // ****
    logic ph_q, wr_q, take, rd, mapped, pend;
    logic [11:0] a_q;
    logic [8:0] ctl_q;
    assign take = HSEL && HREADY && HTRANS[1];
    assign rd = take && !HWRITE;
    assign pend = ph_q && wr_q;
    assign mapped = HADDR inside {APC_AUDIO_CONTROL_OFS, APC_FIELD_CFG_OFS, APC_STATUS_OFS,
        APC_FIFO_DATA_OFS, APC_FIFO_CODE_OFS};
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ph_q <= 1'b0;
            wr_q <= 1'b0;
            a_q <= 12'h000;
            ctl_q <= 9'h000;
        end else begin
            ph_q <= take;
            wr_q <= HWRITE;
            a_q <= HADDR;
            if (pend && a_q == APC_AUDIO_CONTROL_OFS) begin
                ctl_q <= HWDATA[8:0];
            end
        end
    end
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    AST_READY: assert property (HREADYOUT == 1'b1) else $error("wait state inserted");
    AST_OKAY: assert property (HRESP == 1'b0) else $error("error response");
    AST_UNMAPPED: assert property (rd && !mapped |=> HRDATA == 32'h0) else $error("unmapped read");
    AST_HOLD: assert property (!rd |=> $stable(HRDATA)) else $error("read data moved");
    AST_CTRL_BACK: assert property (rd && HADDR == APC_AUDIO_CONTROL_OFS && !pend
        |=> HRDATA[8:0] == ctl_q) else $error("control readback");
    AST_COUNT_MAX: assert property (rd && HADDR == APC_STATUS_OFS
        |=> HRDATA[7:2] <= 6'd35) else $error("count above depth");
    AST_FIFO_OFF: assert property (rd && HADDR == APC_STATUS_OFS && !pend && !ctl_q[APC_FEN_BIT]
        |=> HRDATA[7:2] == APC_CNT_RESET) else $error("count not cleared");
    AST_CODE_SET: assert property (rd && HADDR == APC_FIFO_CODE_OFS
        |=> HRDATA[3:0] inside {4'h0, 4'h1, 4'h6, 4'hc, 4'hd, 4'he, 4'hf}) else $error("bad code");
    cover property (rd && !mapped);
    cover property (rd && HADDR == APC_FIFO_CODE_OFS);
    cover property (rd && HADDR == APC_STATUS_OFS && ctl_q[APC_CAP_BIT]);
endmodule

//--- sim/apc_source.sv
module apc_source (
    output logic bit_clk,
    output logic strobe,
    output logic sdata,
    output logic [23:8] gpio
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // external source, clock idles between frames
    // ****
    initial begin
        bit_clk = 1'b0;
        strobe = 1'b0;
        sdata = 1'b0;
        gpio = 16'h0000;
    end
    task automatic send_byte(input logic [7:0] b, input logic lsb, input logic fall, input logic tog);
        #13 bit_clk = fall;
        for (int i = 0; i < 8; i++) begin
            sdata = lsb ? b[i] : b[7-i];
            #160 bit_clk = ~bit_clk;
            #160 bit_clk = ~bit_clk;
        end
        // released line must not look like held data
        sdata = ~sdata;
        if (tog) begin
            #160 strobe = ~strobe;
        end
        #160;
    endtask
    task automatic resync;
        #160 strobe = ~strobe;
        #160;
    endtask
    task automatic send_word(input logic [15:0] w);
        #13 gpio = w;
        #160 strobe = ~strobe;
        #160 gpio = ~w;
    endtask
endmodule

//--- sim/test_audio_packet_input_capture.sv
module test_audio_packet_input_capture;
    timeunit 1ns;
    timeprecision 1ps;
    import apc_pkg::*;
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic HWRITE = 1'b0;
    logic [11:0] HADDR = 12'h000;
    logic [1:0] HTRANS = 2'h0;
    logic [31:0] HWDATA = 32'h0;
    logic [31:0] HRDATA, q, m, w;
    logic HREADYOUT, HRESP, bit_clk, strobe, sdata;
    logic [23:8] gpio;
    logic [15:0] u;
    logic [3:0] code;
    logic [7:0] exp_b [12];
    // ctrl with capture and fifo enable; the fast serial entry sets byte resolution
    logic [31:0] ctrl_tab [4] = '{32'h191, 32'h1ed, 32'h1a0, 32'h1e0};
    int len_tab [4] = '{11, 11, 10, 11};
    int num_errors = 0;
    int checked = 0;
    int k, i, rem;
    always #20 CLK_SYS = ~CLK_SYS;
    apc_capture dut (.CLK_SYS(CLK_SYS), .RST(RST), .HSEL(1'b1), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'h2), .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SERIAL_BIT_CLOCK(bit_clk), .WORD_STROBE(strobe),
        .SERIAL_DATA_IN(sdata), .GPIO_IN(gpio));
    apc_source src (.bit_clk(bit_clk), .strobe(strobe), .sdata(sdata), .gpio(gpio));
    // ****
    // bus and report tasks
    // ****
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= wr;
        do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
        r = HRDATA;
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #600000;
        num_errors++;
        close_out();
    end
    // ****
    // scenarios
    // ****
    initial begin
        repeat (16) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
        bus(1'b0, APC_AUDIO_CONTROL_OFS, 32'h0, q);
        check("ctrl reset", q, APC_CTRL_RESET);
        bus(1'b0, APC_FIELD_CFG_OFS, 32'h0, q);
        check("field reset", q, APC_FIELD_RESET);
        bus(1'b1, 12'h200, 32'hffff_ffff, q);
        bus(1'b0, 12'h200, 32'h0, q);
        check("unmapped", q, 32'h0);
        for (k = 0; k < 4; k++) begin
            rem = len_tab[k] - 8;
            bus(1'b1, APC_FIELD_CFG_OFS, 32'h1000 | 32'(len_tab[k]), q);
            bus(1'b1, APC_AUDIO_CONTROL_OFS, ctrl_tab[k], q);
            bus(1'b0, APC_AUDIO_CONTROL_OFS, 32'h0, q);
            check("ctrl", q & 32'h1ff, ctrl_tab[k]);
            if (k == 0) begin
                src.resync();
            end
            for (i = 0; i < ((k == 2) ? 5 : 11); i++) begin
                u = 16'hc35a + 16'(i) * 16'h1b27;
                case (k)
                    0: src.send_byte(u[7:0], 1'b0, 1'b0, 1'b0);
                    1: src.send_byte(u[7:0], 1'b1, 1'b1, 1'b1);
                    default: src.send_word(u);
                endcase
                if (k == 2) begin
                    exp_b[2*i] = u[7:0];
                    exp_b[2*i+1] = u[15:8];
                end else begin
                    exp_b[i] = u[7:0];
                end
            end
            i = 0;
            do begin
                bus(1'b0, APC_STATUS_OFS, 32'h0, q);
                i++;
            end while (q[7:2] < 6'd5 && i < 100);
            check("count", {31'h0, q[7:2] >= 6'd5}, 32'h1);
            for (i = 0; i < 5; i++) begin
                code = (i == 0) ? APC_FIELD_START_CODE : (i == 1) ? APC_LINE_START_CODE :
                    (i == 2) ? APC_VALID_SAMPLE_CODE : (i == 3) ? APC_LINE_END_CODE_1 + 4'(rem - 1) :
                    APC_FIELD_END_CODE;
                bus(1'b0, APC_FIFO_CODE_OFS, 32'h0, q);
                check("code", q & 32'hf, {28'h0, code});
                bus(1'b0, APC_FIFO_DATA_OFS, 32'h0, q);
                m = (i != 3) ? 32'hffff_ffff : (rem == 3) ? 32'h00ff_ffff : 32'h0000_ffff;
                w = (i == 0) ? 32'h0 : {exp_b[4*i-1], exp_b[4*i-2], exp_b[4*i-3], exp_b[4*i-4]};
                if (i > 0 && i < 4) begin
                    check("data", q & m, w & m);
                end
            end
            bus(1'b1, APC_AUDIO_CONTROL_OFS, 32'h0, q);
            bus(1'b0, APC_STATUS_OFS, 32'h0, q);
            check("cleared", 32'(q[7:2]), 32'h0);
        end
        close_out();
    end
endmodule
bind apc_capture apc_capture_monitor mon (.CLK_SYS(CLK_SYS), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HWDATA(HWDATA), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP));
